// ===== logic/edcb_alu.sv
/*
  Per channel datapath: homogeneous dot product, half/single conversions
  and high/low bit scans over eight 32-bit channels, two-cycle latency.
  Assumes dispatch supplies legal operands and an old destination value.
*/
// Behaviour
// RULE1 - Fourth first-source element forced one, sum replicated
// RULE2 - Issuer uses size four plus, step one
// RULE3 - 0x14 converts half word to single float
// RULE4 - Half denormals become finite singles, classes kept
// RULE5 - 0x13 to half, single denormals become zero
// RULE6 - Half result in low word, upper kept
// RULE7 - 0x4B high scan gives unsigned count
// RULE8 - Unsigned: zero count from bit 31
// RULE9 - Signed positive: leading zeros like unsigned
// RULE10 - Signed negative: count leading ones
// RULE11 - Zero or signed minus one gives all ones
// RULE12 - 0x4C low scan; zero gives all ones
// RULE13 - Dot product sums element pair products
// RULE14 - Only enabled channels written
`timescale 1ns/1ps
module edcb_alu (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic issueValid,
  input wire logic [7:0] opcode,
  input wire logic srcSigned,
  input wire logic [255:0] srcA,
  input wire logic [255:0] srcB,
  input wire logic [255:0] dstOld,
  input wire logic [7:0] channelWriteEnable,
  output logic resultValid,
  output logic [255:0] resultData,
  output logic [7:0] resultWriteEnable
);
  // Stage one registers
  logic validQ;
  logic [7:0] opQ;
  logic signedQ;
  logic [255:0] aQ;
  logic [255:0] bQ;
  logic [255:0] oldQ;
  logic [7:0] enQ;

  // Capture operands on issue
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      validQ <= 1'b0;
      opQ <= 8'h00;
      signedQ <= 1'b0;
      aQ <= '0;
      bQ <= '0;
      oldQ <= '0;
      enQ <= 8'h00;
    end else begin
      validQ <= issueValid;
      if (issueValid) begin
        opQ <= opcode;
        signedQ <= srcSigned;
        aQ <= srcA;
        bQ <= srcB;
        oldQ <= dstOld;
        enQ <= channelWriteEnable;
      end
    end
  end

  // Per channel and per tuple computation
  logic [255:0] chanRes;
  logic [255:0] dotRes;
  genvar g;
  generate
    for (g = 0; g < edcb_pkg::LANES; g++) begin : gChan
      edcb_scan_conv uScan (
        .opcode(opQ),
        .srcSigned(signedQ),
        .srcWord(aQ[g*32 +: 32]),
        .oldWord(oldQ[g*32 +: 32]),
        .result(chanRes[g*32 +: 32])
      ); // [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12]
    end
    for (g = 0; g < edcb_pkg::LANES / edcb_pkg::TUPLE_W; g++) begin : gTuple
      logic [31:0] acc [0:4];
      assign acc[0] = 32'h00000000;
      for (genvar k = 0; k < edcb_pkg::TUPLE_W; k++) begin : gElem
        // Fourth element of the first source is replaced by one
        logic [31:0] elemA;
        assign elemA = (k == 3) ? edcb_pkg::FP_ONE : aQ[(g*4+k)*32 +: 32]; // [RULE1]
        edcb_fp_mac uMac (
          .mulA(elemA),
          .mulB(bQ[(g*4+k)*32 +: 32]),
          .addC(acc[k]),
          .result(acc[k+1])
        ); // [RULE13]
      end
      // Replicate scalar into all four channels of the tuple
      assign dotRes[g*128 +: 128] = {4{acc[4]}}; // [RULE1]
    end
  endgenerate

  // Result register with per channel merge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      resultValid <= 1'b0;
      resultData <= '0;
      resultWriteEnable <= 8'h00;
    end else begin
      resultValid <= validQ;
      if (validQ) begin
        for (int i = 0; i < edcb_pkg::LANES; i++) begin
          if (!enQ[i]) begin
            resultData[i*32 +: 32] <= oldQ[i*32 +: 32]; // [RULE14]
          end else if (opQ == edcb_pkg::OP_DPH) begin
            resultData[i*32 +: 32] <= dotRes[i*32 +: 32];
          end else begin
            resultData[i*32 +: 32] <= chanRes[i*32 +: 32];
          end
        end
        resultWriteEnable <= enQ; // [RULE14]
      end else begin
        resultWriteEnable <= 8'h00;
      end
    end
  end
endmodule : edcb_alu

// ===== include/edcb_pkg.sv
/*
  Shared constants for the dot product, float conversion and bit scan datapath:
  opcodes, lane counts, float field layouts and the pipeline latency.
  Assumes the includer references items as edcb_pkg::name.
*/
package edcb_pkg;
  // Channel and lane geometry
  localparam int LANES = 8;
  localparam int WORD_W = 32;
  localparam int TUPLE_W = 4;
  // Opcodes handled here
  localparam logic [7:0] OP_DPH = 8'h55;
  localparam logic [7:0] OP_HALF_TO_SINGLE_CONVERT = 8'h14;
  localparam logic [7:0] OP_SINGLE_TO_HALF_CONVERT = 8'h13;
  localparam logic [7:0] OP_SCAN_HI = 8'h4B;
  localparam logic [7:0] OP_SCAN_LO = 8'h4C;
  // Float constants
  localparam logic [31:0] FP_ONE = 32'h3F800000;
  localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] ALL_ZERO = 32'h00000000;
  localparam logic [7:0] SP_EXP_MAX = 8'hFF;
  localparam logic [4:0] HP_EXP_MAX = 5'h1F;
  localparam logic [7:0] SP_BIAS = 8'h7F;
  localparam logic [7:0] HP_BIAS = 8'h0F;
  localparam logic [9:0] HP_QNAN_MAN = 10'h200;
  localparam logic [22:0] SP_QNAN_MAN = 23'h400000;
  // Result latency in cycles from accepted issue to write strobe
  localparam int LATENCY = 2;
endpackage : edcb_pkg

// ===== logic/edcb_fp_mac.sv
/*
  Combinational single precision multiply and add helpers for the dot product.
  Assumes IEEE single precision operands; rounding is truncation, denormals
  are treated as zero and results that overflow saturate to infinity.
*/
`timescale 1ns/1ps
module edcb_fp_mac (
  input wire logic [31:0] mulA,
  input wire logic [31:0] mulB,
  input wire logic [31:0] addC,
  output logic [31:0] result
);
  // Multiply stage
  logic [31:0] prod;
  always_comb begin
    logic [47:0] m;
    logic [9:0] e;
    logic s;
    m = '0;
    e = '0;
    s = mulA[31] ^ mulB[31];
    if (mulA[30:23] == 8'h00 || mulB[30:23] == 8'h00) begin
      // Zero or flushed denormal
      prod = {s, 31'h00000000};
    end else if (mulA[30:23] == 8'hFF || mulB[30:23] == 8'hFF) begin
      // Infinity or NaN propagates as NaN-ish infinity
      prod = {s, 8'hFF, (mulA[22:0] | mulB[22:0])};
    end else begin
      m = {1'b1, mulA[22:0]} * {1'b1, mulB[22:0]};
      e = {2'b00, mulA[30:23]} + {2'b00, mulB[30:23]} - 10'h07F + {9'h000, m[47]};
      if (!m[47]) begin
        m = m << 1;
      end
      if (e[9] || e == 10'h000) begin
        prod = {s, 31'h00000000};
      end else if (e >= 10'h0FF) begin
        prod = {s, 8'hFF, 23'h000000};
      end else begin
        prod = {s, e[7:0], m[46:24]};
      end
    end
  end

  // Add stage: align, add or subtract, normalise
  always_comb begin
    logic [31:0] big;
    logic [31:0] sml;
    logic [26:0] mb;
    logic [26:0] ms;
    logic [27:0] sum;
    logic [7:0] sh;
    logic [8:0] ex;
    big = prod;
    sml = addC;
    sum = '0;
    ex = '0;
    if (addC[30:0] > prod[30:0]) begin
      big = addC;
      sml = prod;
    end
    sh = big[30:23] - sml[30:23];
    mb = (big[30:23] == 8'h00) ? 27'h0 : {1'b1, big[22:0], 3'b000};
    ms = (sml[30:23] == 8'h00) ? 27'h0 : ({1'b1, sml[22:0], 3'b000} >> sh);
    if (big[30:23] == 8'hFF) begin
      result = big;
    end else if (mb == 27'h0) begin
      result = {big[31], 31'h00000000};
    end else begin
      sum = (big[31] == sml[31]) ? {1'b0, mb} + {1'b0, ms} : {1'b0, mb} - {1'b0, ms};
      ex = {1'b0, big[30:23]};
      if (sum[27]) begin
        sum = sum >> 1;
        ex = ex + 9'h001;
      end
      for (int i = 0; i < 26; i++) begin
        if (!sum[26] && sum != 28'h0 && ex > 9'h001) begin
          sum = sum << 1;
          ex = ex - 9'h001;
        end
      end
      if (sum == 28'h0) begin
        result = 32'h00000000;
      end else if (ex >= 9'h0FF) begin
        result = {big[31], 8'hFF, 23'h000000};
      end else begin
        result = {big[31], ex[7:0], sum[25:3]};
      end
    end
  end
endmodule : edcb_fp_mac

// ===== logic/edcb_scan_conv.sv
/*
  Per channel bit scan and half/single conversion, purely combinational.
  Assumes the opcode and signedness come from the same cycle as the operand.
*/
`timescale 1ns/1ps
module edcb_scan_conv (
  input wire logic [7:0] opcode,
  input wire logic srcSigned,
  input wire logic [31:0] srcWord,
  input wire logic [31:0] oldWord,
  output logic [31:0] result
);
  // High side scan value: leading zeros or, for negative signed, leading ones
  logic [31:0] hiScan;
  logic [31:0] loScan;
  always_comb begin
    logic [31:0] v;
    logic found;
    v = (srcSigned && srcWord[31]) ? ~srcWord : srcWord;
    hiScan = edcb_pkg::ALL_ONES;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && v[i]) begin
        hiScan = 32'(31 - i);
        found = 1'b1;
      end
    end
    loScan = edcb_pkg::ALL_ONES;
    found = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!found && srcWord[i]) begin
        loScan = 32'(i);
        found = 1'b1;
      end
    end
  end

  // Half to single
  logic [31:0] toSingle;
  always_comb begin
    logic [9:0] man;
    logic [7:0] ex;
    man = srcWord[9:0];
    // Exponent of a denormal whose top fraction bit is already set
    ex = 8'h70;
    toSingle = {srcWord[15], 31'h00000000};
    if (srcWord[14:10] == edcb_pkg::HP_EXP_MAX) begin
      toSingle = {srcWord[15], edcb_pkg::SP_EXP_MAX, (man == 10'h000) ? 23'h0
                  : (edcb_pkg::SP_QNAN_MAN | {man, 13'h0000})};
    end else if (srcWord[14:10] != 5'h00) begin
      toSingle = {srcWord[15], 8'(srcWord[14:10]) + 8'h70, man, 13'h0000};
    end else if (man != 10'h000) begin
      // Denormal half normalises into a finite single
      for (int i = 0; i < 10; i++) begin
        if (!man[9]) begin
          man = man << 1;
          ex = ex - 8'h01;
        end
      end
      toSingle = {srcWord[15], ex, man[8:0], 14'h0000};
    end
  end

  // Single to half, truncating
  logic [15:0] toHalf;
  always_comb begin
    logic [8:0] e;
    logic [10:0] m;
    e = {1'b0, srcWord[30:23]} - 9'h070;
    m = {1'b1, srcWord[22:13]};
    toHalf = {srcWord[31], 15'h0000};
    if (srcWord[30:23] == edcb_pkg::SP_EXP_MAX) begin
      toHalf = {srcWord[31], edcb_pkg::HP_EXP_MAX, (srcWord[22:0] == 23'h0) ? 10'h0
                : (edcb_pkg::HP_QNAN_MAN | srcWord[22:13])};
    end else if (srcWord[30:23] == 8'h00) begin
      toHalf = {srcWord[31], 15'h0000};
    end else if (srcWord[30:23] > 8'h8E) begin
      toHalf = {srcWord[31], edcb_pkg::HP_EXP_MAX, 10'h000};
    end else if (srcWord[30:23] > 8'h70) begin
      toHalf = {srcWord[31], e[4:0], srcWord[22:13]};
    end else if (srcWord[30:23] > 8'h65) begin
      toHalf = {srcWord[31], 5'h00, 10'(m >> (8'h71 - srcWord[30:23]))};
    end
  end

  // Select by opcode
  always_comb begin
    case (opcode)
      edcb_pkg::OP_SCAN_HI: result = hiScan;
      edcb_pkg::OP_SCAN_LO: result = loScan;
      edcb_pkg::OP_HALF_TO_SINGLE_CONVERT: result = toSingle;
      edcb_pkg::OP_SINGLE_TO_HALF_CONVERT: result = {oldWord[31:16], toHalf};
      default: result = oldWord;
    endcase
  end
endmodule : edcb_scan_conv

// ===== test/edcb_alu_assertions.sv
/* Checker on the datapath ports.
   Assumes it is bound onto edcb_alu with one clock and reset. */
`timescale 1ns/1ps
module edcb_alu_assertions (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic issueValid,
  input wire logic [7:0] opcode,
  input wire logic srcSigned,
  input wire logic [255:0] srcA,
  input wire logic [255:0] srcB,
  input wire logic [255:0] dstOld,
  input wire logic [7:0] channelWriteEnable,
  input wire logic resultValid,
  input wire logic [255:0] resultData,
  input wire logic [7:0] resultWriteEnable
);
  logic [255:0] keepMask; // Lanes not written this cycle
  logic [255:0] old1_q; // Destination one cycle back
  logic [255:0] old2_q; // Destination at issue
  // Mask of disabled lanes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      keepMask[32*i +: 32] = {32{~resultWriteEnable[i]}};
    end
  end
  // Delay line for the old destination
  always_ff @(posedge sys_clk) begin
    old1_q <= dstOld;
    old2_q <= old1_q;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_result_latency: assert property (issueValid |-> ##2 resultValid)
    else $error("result not two cycles after issue");
  a_enable_echo: assert property (
    resultValid |-> resultWriteEnable == $past(channelWriteEnable, 2))
    else $error("write enables differ from issue");
  a_no_stray: assert property (!resultValid |-> resultWriteEnable == 8'h00)
    else $error("write enable without result");
  a_lanes_kept: assert property (
    resultValid |-> ((resultData ^ old2_q) & keepMask) == '0)
    else $error("disabled lane changed");
  a_lo_zero: assert property (
    issueValid && opcode == edcb_pkg::OP_SCAN_LO && channelWriteEnable[0]
    && srcA[31:0] == 32'h0 |-> ##2 resultData[31:0] == edcb_pkg::ALL_ONES)
    else $error("low scan of zero wrong");
  a_hi_zero: assert property (
    issueValid && opcode == edcb_pkg::OP_SCAN_HI && channelWriteEnable[0]
    && srcA[31:0] == 32'h0 |-> ##2 resultData[31:0] == edcb_pkg::ALL_ONES)
    else $error("high scan of zero wrong");
  a_hi_top: assert property (
    issueValid && opcode == edcb_pkg::OP_SCAN_HI && !srcSigned
    && srcA[31] && channelWriteEnable[0] |-> ##2 resultData[31:0] == 32'h0)
    else $error("high scan with top bit set wrong");
  a_dph_replicate: assert property (
    issueValid && opcode == edcb_pkg::OP_DPH
    && channelWriteEnable[3:0] == 4'hF |-> ##2 resultData[63:32] == resultData[31:0]
    && resultData[127:96] == resultData[95:64] && resultData[95:64] == resultData[31:0])
    else $error("dot product not replicated");
  a_half_upper: assert property (
    resultValid && resultWriteEnable[0] && $past(opcode, 2)
    == edcb_pkg::OP_SINGLE_TO_HALF_CONVERT |-> resultData[31:16] == old2_q[31:16])
    else $error("upper word changed by half result");
endmodule : edcb_alu_assertions

bind edcb_alu edcb_alu_assertions chk (.sys_clk, .reset, .issueValid, .opcode, .srcSigned,
  .srcA, .srcB, .dstOld, .channelWriteEnable, .resultValid, .resultData, .resultWriteEnable);

// ===== test/edcb_regfile_model.sv
/* Register file model behind the datapath: one destination, lane write-back.
   Assumes the same clock and reset as the design. */
`timescale 1ns/1ps
module edcb_regfile_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [255:0] loadValue,
  input wire logic resultValid,
  input wire logic [255:0] resultData,
  input wire logic [7:0] resultWriteEnable,
  output logic [255:0] dstOld
);
  // Preset by the issuer, then write-back of enabled lanes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dstOld <= '0;
    end else if (load) begin // Aligned destination, step one lanes
      dstOld <= loadValue;
    end else if (resultValid) begin
      for (int i = 0; i < 8; i++) begin
        if (resultWriteEnable[i]) begin // Enabled lanes only
          dstOld[32*i +: 32] <= resultData[32*i +: 32];
        end
      end
    end
  end
endmodule : edcb_regfile_model

// ===== test/edcb_alu_tb.sv
/* Self-checking bench for edcb_alu.
   Assumes the register file model and the bound checker are compiled. */
`timescale 1ns/1ps
module edcb_alu_tb;
  typedef struct packed {logic [7:0] op; logic sg; logic [31:0] a; logic [31:0] e;} edcb_row_t;
  logic sys_clk, reset, issueValid, srcSigned, resultValid, load;
  logic [7:0] opcode, channelWriteEnable, resultWriteEnable;
  logic [255:0] srcA, srcB, dstOld, resultData, loadValue, exp;
  int fails = 0, num_checks = 0, cycles = 0;
  // Word-typed half sources sit in the low word
  edcb_row_t rows [18] = '{
    '{8'h14, 1'b0, 32'h00003C00, 32'h3F800000}, '{8'h14, 1'b0, 32'h0000FC00, 32'hFF800000},
    '{8'h14, 1'b0, 32'h00008000, 32'h80000000}, '{8'h14, 1'b0, 32'h00008001, 32'hB3800000},
    '{8'h14, 1'b0, 32'h00007E00, 32'h7FC00000}, '{8'h13, 1'b0, 32'h3F800000, 32'hA5A53C00},
    '{8'h13, 1'b0, 32'hFF800000, 32'hA5A5FC00}, '{8'h13, 1'b0, 32'h80000001, 32'hA5A58000},
    '{8'h13, 1'b0, 32'h7FC00000, 32'hA5A57E00}, '{8'h4B, 1'b0, 32'h00010000, 32'h0000000F},
    '{8'h4B, 1'b0, 32'hFFFFFFFF, 32'h00000000}, '{8'h4B, 1'b1, 32'h00000001, 32'h0000001F},
    '{8'h4B, 1'b1, 32'hFFFF0000, 32'h00000010}, '{8'h4B, 1'b1, 32'hFFFFFFFF, 32'hFFFFFFFF},
    '{8'h4C, 1'b0, 32'h00000100, 32'h00000008}, '{8'h4C, 1'b0, 32'h80000000, 32'h0000001F},
    '{8'h00, 1'b0, 32'h00000001, 32'hA5A50000}, '{8'h4C, 1'b0, 32'h00000000, 32'hFFFFFFFF}};
  edcb_alu dut (.sys_clk, .reset, .issueValid, .opcode, .srcSigned, .srcA, .srcB, .dstOld,
    .channelWriteEnable, .resultValid, .resultData, .resultWriteEnable);
  edcb_regfile_model rf (.sys_clk, .reset, .load, .loadValue, .resultValid, .resultData,
    .resultWriteEnable, .dstOld);
  // Free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic check(input string nm, input logic [255:0] seen, input logic [255:0] e);
    num_checks++;
    if (seen !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, seen);
    end
  endtask : check
  task automatic preset(input logic [255:0] v);
    load = 1'b1;
    loadValue = v;
    @(posedge sys_clk) #1;
    load = 1'b0;
  endtask : preset
  task automatic run(input logic [7:0] op, input logic sg, input logic [255:0] a,
    input logic [255:0] b, input logic [7:0] en);
    opcode = op;
    srcSigned = sg;
    srcA = a;
    srcB = b;
    channelWriteEnable = en;
    issueValid = 1'b1;
    @(posedge sys_clk) #1;
    issueValid = 1'b0;
    for (int k = 0; k < 4 && resultValid !== 1'b1; k++) @(posedge sys_clk) #1;
  endtask : run
  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    {issueValid, srcSigned, load, opcode, channelWriteEnable} = '0;
    {srcA, srcB, loadValue} = '0;
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("reset valid", resultValid, 1'b0);
    check("reset enables", resultWriteEnable, 8'h00);
    check("reset data", resultData, '0);
    reset = 1'b0;
    $display("test reset done");
    foreach (rows[r]) begin
      preset({8{32'hA5A50000}});
      run(rows[r].op, rows[r].sg, {8{rows[r].a}}, '0, 8'hFF);
      exp = {8{rows[r].e}};
      check("lo", resultData[127:0], exp[127:0]);
      check("hi", resultData[255:128], exp[255:128]);
    end
    $display("test rows done");
    run(8'h55, 1'b0, {32'h40E00000, 64'h0, 32'h40000000, 32'h40A00000, 32'h40400000,
      32'h40000000, 32'h3F800000}, {32'h3F000000, 64'h0, 32'h40000000, 32'h40800000,
      {3{32'h3F800000}}}, 8'hFF);
    check("dot product", resultData, {{4{32'h40900000}}, {4{32'h41200000}}});
    $display("test dot done");
    preset({8{32'h12345678}});
    run(8'h4C, 1'b0, {8{32'h00000100}}, '0, 8'h5A);
    for (int i = 0; i < 8; i++) exp[32*i +: 32] = (8'h5A >> i) & 1 ? 32'h8 : 32'h12345678;
    check("masked lanes", resultData, exp);
    check("masked enables", resultWriteEnable, 8'h5A);
    $display("test mask done");
    srcA = {8{32'h00000000}};
    {opcode, srcSigned, channelWriteEnable, issueValid} = {8'h4B, 1'b0, 8'hFF, 1'b1};
    @(posedge sys_clk) #1;
    srcA = {8{32'h00000010}};
    opcode = 8'h4C;
    @(posedge sys_clk) #1;
    issueValid = 1'b0;
    check("first valid", resultValid, 1'b1);
    check("first of pair", resultData, {8{32'hFFFFFFFF}});
    @(posedge sys_clk) #1;
    check("second valid", resultValid, 1'b1);
    check("second of pair", resultData, {8{32'h4}});
    $display("test pair done");
    issueValid = 1'b1;
    @(posedge sys_clk) #1;
    {issueValid, reset} = 2'b01;
    @(posedge sys_clk) #1;
    reset = 1'b0;
    repeat (3) @(posedge sys_clk) #1 check("after reset", resultValid, 1'b0);
    $display("test midreset done");
    end_of_test();
  end
endmodule : edcb_alu_tb
